// *** dv/dpc_host_model.sv ***
// Host model issuing single-byte register accesses
`timescale 1ns/1ps
module dpc_host_model (
  // Clock
  input wire logic i_clk,
  // Register port
  output dpc_pkg::dpc_req_s o_req,
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_valid
);
  initial o_req = '0;
  // Reserved bits always go out as zero
  function automatic logic [7:0] keep(input logic [7:0] a);
    case (a)
      8'h01: keep = 8'h01;
      8'h02: keep = 8'h3F;
      8'h03: keep = 8'h01;
      default: keep = 8'hFF;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d & keep(a)};
    @(posedge i_clk);
    o_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    o_req <= '0;
    #1;
    // Data only counts while the valid pulse stands
    d = (i_rd_valid === 1'b1) ? i_rd_data : 8'hXX;
  endtask
endmodule

// *** dv/dpc_power_ctrl_bench.sv ***
// Self-checking bench for the power and page control block
`timescale 1ns/1ps
module dpc_power_ctrl_bench;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  dpc_pkg::dpc_req_s req;
  logic [7:0] rdat;
  logic rval;
  logic a3 = 1'b0;
  logic io3 = 1'b0;
  logic uv = 1'b0;
  logic [7:0] sta = 8'h5A;
  logic [7:0] stb = 8'hA5;
  logic run, digital_regulator, refen, qc, amode, iomode;
  logic [7:0] page;
  logic [dpc_pkg::NMAP*8-1:0] map;
  int mismatches = 0;
  int samples_checked = 0;
  int n;
  logic [7:0] d;
  logic [7:0] maddr [18] = '{8'h66, 8'h67, 8'h68, 8'h69, 8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E,
    8'h6F, 8'h70, 8'h71, 8'h72, 8'h73, 8'h76, 8'h77, 8'h78, 8'h7E};
  logic [7:0] mdef [18] = '{8'h20, 8'hC9, 8'h80, 8'hC9, 8'h80, 8'h20, 8'h20, 8'h20, 8'hC9,
    8'h80, 8'hC9, 8'h80, 8'h18, 8'h18, 8'hCC, 8'h00, 8'h00, 8'h00};
  // Short charge counts keep the run brief
  int qlen [4] = '{5, 8, 12, 16};

  always #50 i_clk = ~i_clk;

  dpc_host_model i_dpc_host_model (.i_clk(i_clk), .o_req(req), .i_rd_data(rdat), .i_rd_valid(rval));

  dpc_power_ctrl #(.QCHG_CYC0(5), .QCHG_CYC1(8), .QCHG_CYC2(12), .QCHG_CYC3(16)) i_dpc_power_ctrl (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .o_rd_data(rdat), .o_rd_valid(rval),
    .i_analog_3v3_detect(a3), .i_io_3v3_detect(io3), .i_undervoltage(uv),
    .i_status_a(sta), .i_status_b(stb), .o_run_not_sleep(run), .o_digital_regulator_en(digital_regulator),
    .o_reference_en(refen), .o_reference_quick_charge(qc), .o_analog_supply_mode(amode),
    .o_io_supply_mode(iomode), .o_page(page), .o_map_cfg(map));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_dpc_host_model.wr(a, v);
    // Step off the launching edge so outputs are settled when looked at
    #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    i_dpc_host_model.rd(a, d);
    chk(d, exp);
  endtask
  task automatic defaults;
    for (int k = 0; k < 18; k++) begin
      rc(maddr[k], mdef[k]);
      chk(map[8*k +: 8], mdef[k]);
    end
    for (int k = 0; k < 4; k++) begin
      rc(8'(k), 8'h00);
    end
  endtask
  task automatic uv_pulse;
    @(posedge i_clk);
    uv <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk(8'(run), 8'h00);
    uv <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic close_out;
    $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    close_out();
  end

  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    defaults();
    rc(8'h79, 8'h5A);
    rc(8'h7A, 8'hA5);
    $display("Test reset values done");
    wr(8'h00, 8'h05);
    rc(8'h00, 8'h05);
    wr(8'h02, 8'h01);
    rc(8'h02, 8'h00);
    wr(8'h00, 8'hFF);
    rc(8'h00, 8'hFF);
    wr(8'h00, 8'h00);
    chk(page, 8'h00);
    $display("Test paging done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h02, 8'h00);
      chk(8'({digital_regulator, refen, run}), 8'h00);
      wr(8'h02, 8'(c << 4) | 8'h09);
      n = 0;
      repeat (24) begin
        #1;
        if (qc === 1'b1) n++;
        @(posedge i_clk);
      end
      chk(8'(n), 8'(qlen[c]));
      chk(8'({digital_regulator, refen, run}), 8'h07);
      rc(8'h02, 8'(c << 4) | 8'h09);
    end
    wr(8'h02, 8'h01);
    chk(8'({digital_regulator, refen, run}), 8'h05);
    $display("Test sleep and charge done");
    wr(8'h02, 8'h07);
    chk(8'({amode, iomode}), 8'h03);
    @(posedge i_clk);
    a3 <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    chk(8'({amode, iomode}), 8'h01);
    rc(8'h03, 8'h80);
    io3 <= 1'b1;
    rc(8'h03, 8'hC0);
    chk(8'({amode, iomode}), 8'h00);
    a3 <= 1'b0;
    io3 <= 1'b0;
    rc(8'h03, 8'h00);
    chk(8'({amode, iomode}), 8'h03);
    $display("Test supply modes done");
    wr(8'h03, 8'h01);
    uv_pulse();
    chk(8'(run), 8'h01);
    rc(8'h03, 8'h03);
    wr(8'h03, 8'h00);
    uv_pulse();
    chk(8'(run), 8'h00);
    rc(8'h03, 8'h02);
    $display("Test undervoltage done");
    wr(8'h7E, 8'hAB);
    wr(8'h01, 8'h00);
    rc(8'h7E, 8'hAB);
    wr(8'h00, 8'h07);
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h01);
    repeat (3) @(posedge i_clk);
    rc(8'h01, 8'h00);
    defaults();
    chk(8'(run), 8'h00);
    $display("Test soft reset done");
    close_out();
  end
endmodule

// *** rtl/dpc_pkg.sv ***
// Types of the power and page control block
package dpc_pkg;
  localparam int NMAP = 18;
  localparam int QW = 20;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dpc_req_s;

  typedef struct packed {
    logic [7:0] page;
    logic srst_pend;
    logic [1:0] qchg_time;
    logic exit_ref_en;
    logic analog_mode;
    logic io_mode;
    logic run;
    logic uv_flag;
    logic uv_wake;
    logic uv_prev;
    logic [QW-1:0] qcnt;
    logic qchg;
    logic ref_en;
    logic analog_eff;
    logic io_eff;
    logic a_ovr;
    logic io_ovr;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [NMAP-1:0][7:0] map;
  } dpc_state_s;
endpackage

// *** rtl/dpc_power_ctrl.sv ***
// Device power, sleep, supply mode and page control register block
// Notes on behaviour
// - Eight-bit page register at address zero
// - Writing one resets every register to default, except the undervoltage flag if undervoltage rises in the reset cycle
// - Soft reset bit clears itself afterwards
// - Two-bit code picks reference quick-charge length
// - Bit three adds reference on sleep exit
// - Bit two picks analog supply mode
// - Bit one picks I/O supply mode
// - Run bit zero means sleep
// - Analog override flag shows forced mode
// - I/O override flag shows forced mode
// - Undervoltage flag records a shutdown
// - Wake select decides sleep after shutdown
`timescale 1ns/1ps
`include "dpc_regs.svh"
module dpc_power_ctrl #(
  parameter int QCHG_CYC0 = `DPC_QCHG0_US * `DPC_CLK_MHZ,
  parameter int QCHG_CYC1 = `DPC_QCHG1_US * `DPC_CLK_MHZ,
  parameter int QCHG_CYC2 = `DPC_QCHG2_US * `DPC_CLK_MHZ,
  parameter int QCHG_CYC3 = `DPC_QCHG3_US * `DPC_CLK_MHZ
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Decoded control bus transaction
  input wire dpc_pkg::dpc_req_s i_req,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  // Supply monitors and device status
  input wire logic i_analog_3v3_detect,
  input wire logic i_io_3v3_detect,
  input wire logic i_undervoltage,
  input wire logic [7:0] i_status_a,
  input wire logic [7:0] i_status_b,
  // Power controls, page and map configuration
  output logic o_run_not_sleep,
  output logic o_digital_regulator_en,
  output logic o_reference_en,
  output logic o_reference_quick_charge,
  output logic o_analog_supply_mode,
  output logic o_io_supply_mode,
  output logic [7:0] o_page,
  output logic [dpc_pkg::NMAP*8-1:0] o_map_cfg
);
  // Map entry k sits at bits [8k+7:8k] of o_map_cfg, lowest address first
  localparam logic [dpc_pkg::NMAP-1:0][7:0] MAP_ADDR = {
    `DPC_A_CKSUM,
    `DPC_A_PWR_UP,
    `DPC_A_DYN_PU,
    `DPC_A_CHANNEL_ENABLE_CONFIG,
    `DPC_A_DSP_B,
    `DPC_A_DSP_A,
    `DPC_A_DAC2B_B,
    `DPC_A_DAC2B_A,
    `DPC_A_DAC2A_B,
    `DPC_A_DAC2A_A,
    `DPC_A_OUT2_C,
    `DPC_A_OUT2_B,
    `DPC_A_OUT2_A,
    `DPC_A_DAC1B_B,
    `DPC_A_DAC1B_A,
    `DPC_A_DAC1A_B,
    `DPC_A_DAC1A_A,
    `DPC_A_OUT1_C
  };
  localparam logic [dpc_pkg::NMAP-1:0][7:0] MAP_RST = {
    `DPC_R_ZERO,
    `DPC_R_ZERO,
    `DPC_R_ZERO,
    `DPC_R_CHANNEL_ENABLE_CONFIG,
    `DPC_R_DSP,
    `DPC_R_DSP,
    `DPC_R_DAC_B,
    `DPC_R_DAC_A,
    `DPC_R_DAC_B,
    `DPC_R_DAC_A,
    `DPC_R_OUT,
    `DPC_R_OUT,
    `DPC_R_OUT,
    `DPC_R_DAC_B,
    `DPC_R_DAC_A,
    `DPC_R_DAC_B,
    `DPC_R_DAC_A,
    `DPC_R_OUT
  };
  localparam logic [1:0] QCHG_MAX = 2'h3;

  dpc_pkg::dpc_state_s s;
  dpc_pkg::dpc_state_s next_s;
  logic [dpc_pkg::NMAP-1:0] hit;
  logic on_page0;

  function automatic dpc_pkg::dpc_state_s reset_state();
    dpc_pkg::dpc_state_s r;
    r = '0;
    r.page = `DPC_RST_PAGE;
    r.srst_pend = 1'b0;
    r.qchg_time = 2'h0;
    r.exit_ref_en = 1'b0;
    r.analog_mode = 1'b0;
    r.io_mode = 1'b0;
    // Sleep is the power-on state
    r.run = 1'b0;
    r.uv_flag = 1'b0;
    r.uv_wake = 1'b0;
    r.map = MAP_RST;
    return r;
  endfunction

  // Charge length in clock cycles for each code; a function keeps the load free of a combinational loop
  function automatic logic [dpc_pkg::QW-1:0] qchg_cycles(input logic [1:0] code);
    logic [dpc_pkg::QW-1:0] c;
    case (code)
      2'h0: c = dpc_pkg::QW'(QCHG_CYC0);
      2'h1: c = dpc_pkg::QW'(QCHG_CYC1);
      2'h2: c = dpc_pkg::QW'(QCHG_CYC2);
      QCHG_MAX: c = dpc_pkg::QW'(QCHG_CYC3);
      default: c = dpc_pkg::QW'(QCHG_CYC0);
    endcase
    return c;
  endfunction

  // One comparator per map entry; only page 0 holds these registers
  genvar gi;
  generate
    for (gi = 0; gi < dpc_pkg::NMAP; gi++) begin : g_hit
      assign hit[gi] = on_page0 && (i_req.addr == MAP_ADDR[gi]);
    end
  endgenerate

  assign on_page0 = (s.page == `DPC_RST_PAGE);

  always_comb begin
    next_s = s;
    next_s.rd_valid = 1'b0;
    next_s.uv_prev = i_undervoltage;
    if (s.srst_pend) begin
      // Whole map back to power-on values, the request bit included
      next_s = reset_state();
      next_s.uv_prev = i_undervoltage;
    end else if (i_req.wr) begin
      if (i_req.addr == `DPC_ADDR_PAGE) begin
        next_s.page = i_req.wdata;
      end else if (on_page0) begin
        // Reserved bits are simply not stored, so they read back as zero
        case (i_req.addr)
          `DPC_ADDR_SRST: begin
            next_s.srst_pend = i_req.wdata[`DPC_BIT_SRST];
          end
          `DPC_ADDR_MISC: begin
            next_s.qchg_time = i_req.wdata[`DPC_LSB_QCHG +: 2];
            next_s.exit_ref_en = i_req.wdata[`DPC_BIT_EXIT_REF];
            next_s.analog_mode = i_req.wdata[`DPC_BIT_AMODE];
            next_s.io_mode = i_req.wdata[`DPC_BIT_IOMODE];
            next_s.run = i_req.wdata[`DPC_BIT_RUN];
          end
          `DPC_ADDR_SUPPLY: begin
            next_s.uv_wake = i_req.wdata[`DPC_BIT_UVWAKE];
          end
          default: begin
            for (int k = 0; k < dpc_pkg::NMAP; k++) begin
              if (hit[k]) begin
                next_s.map[k] = i_req.wdata;
              end
            end
          end
        endcase
      end
    end
    // Undervoltage wins over a soft reset in the same cycle so the event is kept
    if (i_undervoltage) begin
      next_s.run = 1'b0;
      if (!s.uv_prev) begin
        next_s.uv_flag = 1'b1;
      end
    end else if (s.uv_prev) begin
      next_s.run = next_s.uv_wake;
    end
    // Quick charge starts on each sleep exit that also brings up the reference
    if (next_s.run && !s.run && next_s.exit_ref_en) begin
      next_s.qchg = 1'b1;
      next_s.qcnt = qchg_cycles(next_s.qchg_time) - 1'b1;
    end else if (s.qchg) begin
      if (s.qcnt == '0 || !next_s.run) begin
        next_s.qchg = 1'b0;
      end else begin
        next_s.qcnt = s.qcnt - 1'b1;
      end
    end
    // A detected 3.3 V supply forces the matching mode to zero
    next_s.a_ovr = i_analog_3v3_detect;
    next_s.io_ovr = i_io_3v3_detect;
    next_s.analog_eff = next_s.analog_mode && !i_analog_3v3_detect;
    next_s.io_eff = next_s.io_mode && !i_io_3v3_detect;
    next_s.ref_en = next_s.run && next_s.exit_ref_en;
    // A read in the cycle that carries out a soft reset is dropped, like a write
    if (i_req.rd && !s.srst_pend) begin
      next_s.rd_valid = 1'b1;
      next_s.rd_data = 8'h00;
      if (i_req.addr == `DPC_ADDR_PAGE) begin
        next_s.rd_data = s.page;
      end else if (on_page0) begin
        case (i_req.addr)
          `DPC_ADDR_SRST: begin
            next_s.rd_data = {7'h00, s.srst_pend};
          end
          `DPC_ADDR_MISC: begin
            next_s.rd_data = {2'h0, s.qchg_time, s.exit_ref_en, s.analog_mode, s.io_mode, s.run};
          end
          `DPC_ADDR_SUPPLY: begin
            next_s.rd_data = {s.a_ovr, s.io_ovr, 4'h0, s.uv_flag, s.uv_wake};
          end
          `DPC_ADDR_STS_A: begin
            next_s.rd_data = i_status_a;
          end
          `DPC_ADDR_STS_B: begin
            next_s.rd_data = i_status_b;
          end
          default: begin
            for (int k = 0; k < dpc_pkg::NMAP; k++) begin
              if (hit[k]) begin
                next_s.rd_data = s.map[k];
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= reset_state();
    end else begin
      s <= next_s;
    end
  end

  assign o_rd_data = s.rd_data;
  assign o_rd_valid = s.rd_valid;
  assign o_run_not_sleep = s.run;
  assign o_digital_regulator_en = s.run;
  assign o_reference_en = s.ref_en;
  assign o_reference_quick_charge = s.qchg;
  assign o_analog_supply_mode = s.analog_eff;
  assign o_io_supply_mode = s.io_eff;
  assign o_page = s.page;
  assign o_map_cfg = s.map;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence page_wr_seq;
    i_req.wr && i_req.addr == `DPC_ADDR_PAGE && !s.srst_pend;
  endsequence
  sequence srst_wr_seq;
    i_req.wr && on_page0 && i_req.addr == `DPC_ADDR_SRST && i_req.wdata[0] && !s.srst_pend;
  endsequence

  a_page_any_write: assert property (page_wr_seq |=> o_page == $past(i_req.wdata))
    else $error("page register not written");
  a_srst_self_clear: assert property (srst_wr_seq |=> s.srst_pend ##1 !s.srst_pend)
    else $error("soft reset bit did not clear itself");
  a_srst_defaults: assert property (srst_wr_seq ##1 1'b1 |=> o_page == 8'h00 && s.map == MAP_RST && !s.analog_mode)
    else $error("soft reset did not restore defaults");
  a_qchg_load: assert property ($rose(s.qchg) |-> s.qcnt == qchg_cycles(s.qchg_time) - 1'b1)
    else $error("quick charge length wrong");
  a_qchg_needs_ref: assert property ($rose(s.qchg) |-> s.exit_ref_en && s.run && !$past(s.run))
    else $error("quick charge without reference exit");
  a_analog_force: assert property (i_analog_3v3_detect |=> !o_analog_supply_mode && s.a_ovr)
    else $error("analog mode not forced");
  a_io_force: assert property (i_io_3v3_detect |=> !o_io_supply_mode && s.io_ovr)
    else $error("io mode not forced");
  a_uv_flag_set: assert property ($rose(i_undervoltage) |=> s.uv_flag && !o_run_not_sleep)
    else $error("undervoltage not recorded");
  a_uv_wake_sel: assert property ($fell(i_undervoltage) && !s.srst_pend |=> o_run_not_sleep == $past(s.uv_wake))
    else $error("sleep after undervoltage wrong");
  a_sleep_regs: assert property (!o_run_not_sleep |-> !o_digital_regulator_en && !o_reference_en)
    else $error("regulators on during sleep");
  a_reserved_zero: assert property (o_rd_valid && $past(i_req.addr) == `DPC_ADDR_MISC && $past(on_page0)
    |-> o_rd_data[7:6] == 2'h0)
    else $error("reserved bits not zero");

  sequence misc_wr_seq;
    i_req.wr && on_page0 && i_req.addr == `DPC_ADDR_MISC && !s.srst_pend;
  endsequence
  sequence page_rd_seq;
    i_req.rd && i_req.addr == `DPC_ADDR_PAGE && !s.srst_pend;
  endsequence
  sequence supply_rd_seq;
    i_req.rd && on_page0 && i_req.addr == `DPC_ADDR_SUPPLY && !s.srst_pend;
  endsequence
  sequence off_page_rd_seq;
    i_req.rd && !on_page0 && i_req.addr != `DPC_ADDR_PAGE && !s.srst_pend;
  endsequence
  sequence off_page_wr_seq;
    i_req.wr && !on_page0 && i_req.addr != `DPC_ADDR_PAGE && !s.srst_pend;
  endsequence

  a_page_readback: assert property (page_rd_seq |=> o_rd_valid && o_rd_data == $past(s.page))
    else $error("page register read back wrong");
  a_off_page_read: assert property (off_page_rd_seq |=> o_rd_valid && o_rd_data == 8'h00)
    else $error("read on another page not zero");
  a_off_page_write: assert property (off_page_wr_seq |=> s.map == $past(s.map) && s.qchg_time == $past(s.qchg_time))
    else $error("write on another page changed a register");
  a_misc_fields: assert property (misc_wr_seq |=> s.analog_mode == $past(i_req.wdata[`DPC_BIT_AMODE])
    && s.io_mode == $past(i_req.wdata[`DPC_BIT_IOMODE]) && s.exit_ref_en == $past(i_req.wdata[`DPC_BIT_EXIT_REF]))
    else $error("misc config fields not stored");
  a_run_write: assert property (i_req.wr && on_page0 && i_req.addr == `DPC_ADDR_MISC && !s.srst_pend
    && !i_undervoltage && !s.uv_prev |=> o_run_not_sleep == $past(i_req.wdata[`DPC_BIT_RUN]))
    else $error("run bit not applied");
  a_supply_read: assert property (supply_rd_seq |=> o_rd_data[7:6] == {$past(s.a_ovr), $past(s.io_ovr)})
    else $error("override flags read wrong");
  a_uv_flag_read: assert property (supply_rd_seq |=> o_rd_data[1] == $past(s.uv_flag))
    else $error("undervoltage flag read wrong");
  a_supply_reserved: assert property (supply_rd_seq |=> o_rd_data[5:2] == 4'h0)
    else $error("supply status reserved bits not zero");
  a_srst_reserved: assert property (o_rd_valid && $past(i_req.addr) == `DPC_ADDR_SRST && $past(on_page0)
    |-> o_rd_data[7:1] == 7'h00)
    else $error("soft reset reserved bits not zero");
  a_rd_valid_pulse: assert property (!i_req.rd |=> !o_rd_valid)
    else $error("read valid without a read");
  a_sts_a_read: assert property (i_req.rd && on_page0 && i_req.addr == `DPC_ADDR_STS_A && !s.srst_pend
    |=> o_rd_data == $past(i_status_a))
    else $error("status byte a read wrong");
  a_sts_b_read: assert property (i_req.rd && on_page0 && i_req.addr == `DPC_ADDR_STS_B && !s.srst_pend
    |=> o_rd_data == $past(i_status_b))
    else $error("status byte b read wrong");
  a_srst_zero_write: assert property (i_req.wr && on_page0 && i_req.addr == `DPC_ADDR_SRST
    && !i_req.wdata[`DPC_BIT_SRST] && !s.srst_pend |=> !s.srst_pend)
    else $error("writing zero started a soft reset");
  a_digital_regulator_follows: assert property (o_digital_regulator_en == o_run_not_sleep)
    else $error("digital regulator not following run");
  a_ref_needs_bit: assert property (o_reference_en |-> s.exit_ref_en && o_run_not_sleep)
    else $error("reference on without its exit bit");
  a_qchg_sleep_off: assert property (!o_run_not_sleep |-> !o_reference_quick_charge)
    else $error("quick charge running in sleep");
  a_analog_free: assert property (!i_analog_3v3_detect |=> o_analog_supply_mode == s.analog_mode)
    else $error("analog mode not as configured");
  a_io_free: assert property (!i_io_3v3_detect |=> o_io_supply_mode == s.io_mode)
    else $error("io mode not as configured");
  a_uv_holds_sleep: assert property (i_undervoltage |=> !o_run_not_sleep)
    else $error("awake during undervoltage");
  a_uv_flag_sticky: assert property (s.uv_flag && !s.srst_pend |=> s.uv_flag)
    else $error("undervoltage flag lost");

  // Each map entry stores a page 0 write and returns it on a read
  generate
    for (gi = 0; gi < dpc_pkg::NMAP; gi++) begin : g_map_chk
      a_map_write: assert property (i_req.wr && hit[gi] && !s.srst_pend |=> s.map[gi] == $past(i_req.wdata))
        else $error("map register write lost");
      a_map_read: assert property (i_req.rd && hit[gi] && !s.srst_pend |=> o_rd_data == $past(s.map[gi]))
        else $error("map register read wrong");
    end
  endgenerate
endmodule

// *** rtl/dpc_regs.svh ***
// Register offsets, field positions, reset values and timing of the power and page control block
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH
`define DPC_CLK_MHZ 10
`define DPC_QCHG0_US 3500
`define DPC_QCHG1_US 10000
`define DPC_QCHG2_US 50000
`define DPC_QCHG3_US 100000
`define DPC_ADDR_PAGE 8'h00
`define DPC_ADDR_SRST 8'h01
`define DPC_ADDR_MISC 8'h02
`define DPC_ADDR_SUPPLY 8'h03
`define DPC_ADDR_STS_A 8'h79
`define DPC_ADDR_STS_B 8'h7A
`define DPC_RST_PAGE 8'h00
`define DPC_RST_STS_B 8'h80
`define DPC_BIT_SRST 0
`define DPC_LSB_QCHG 4
`define DPC_BIT_EXIT_REF 3
`define DPC_BIT_AMODE 2
`define DPC_BIT_IOMODE 1
`define DPC_BIT_RUN 0
`define DPC_BIT_AOVR 7
`define DPC_BIT_IOOVR 6
`define DPC_BIT_UVFLAG 1
`define DPC_BIT_UVWAKE 0
`define DPC_A_OUT1_C 8'h66
`define DPC_A_DAC1A_A 8'h67
`define DPC_A_DAC1A_B 8'h68
`define DPC_A_DAC1B_A 8'h69
`define DPC_A_DAC1B_B 8'h6A
`define DPC_A_OUT2_A 8'h6B
`define DPC_A_OUT2_B 8'h6C
`define DPC_A_OUT2_C 8'h6D
`define DPC_A_DAC2A_A 8'h6E
`define DPC_A_DAC2A_B 8'h6F
`define DPC_A_DAC2B_A 8'h70
`define DPC_A_DAC2B_B 8'h71
`define DPC_A_DSP_A 8'h72
`define DPC_A_DSP_B 8'h73
`define DPC_A_CHANNEL_ENABLE_CONFIG 8'h76
`define DPC_A_DYN_PU 8'h77
`define DPC_A_PWR_UP 8'h78
`define DPC_A_CKSUM 8'h7E
`define DPC_R_OUT 8'h20
`define DPC_R_DAC_A 8'hC9
`define DPC_R_DAC_B 8'h80
`define DPC_R_DSP 8'h18
`define DPC_R_CHANNEL_ENABLE_CONFIG 8'hCC
`define DPC_R_ZERO 8'h00
`endif
